// File: sasc_pkg.sv
package sasc_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int NODE_W = 8;
  localparam int SUM_W = 16;
  localparam int EVT_W = 5;

  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_NODE = 4'h1;
  localparam logic [3:0] OFS_MAP_SUM = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
  localparam logic [3:0] OFS_CTRL_WORD = 4'h6;

  // Field positions
  localparam int CTRL_SLAVE_EN_BIT = 0;
  localparam int ST_PENDING_BIT = 0;
  localparam int ST_CLEAR_BIT = 1;
  localparam int ST_ACK_BIT = 2;
  localparam int ST_CONFLICT_BIT = 3;
  localparam int ST_MAP_FAIL_BIT = 4;
  localparam int ST_NODE_LSB = 8;
  localparam int CW_RAISE_BIT = 15;

  // Event bits of status and mask
  localparam int EV_NOTIFY = 0;
  localparam int EV_ACKED = 1;
  localparam int EV_CLEAR = 2;
  localparam int EV_MAP_FAIL = 3;
  localparam int EV_CONFLICT = 4;

  // Reset values
  localparam logic CTRL_RST = 1'b0;
  localparam logic [7:0] NODE_RST = 8'h00;
  localparam logic [15:0] MAP_SUM_RST = 16'h0000;
  localparam logic [4:0] MASK_RST = 5'h00;

  // Alarm tracker states, Gray along idle, pending, acked
  typedef enum logic [1:0] {
    SASC_IDLE = 2'b00,
    SASC_PEND = 2'b01,
    SASC_ACKD = 2'b11
  } sasc_alarm_state_t;

  // Controller output control word
  typedef struct packed {
    logic [7:0] node_id_value;
    logic alarm_raise_request;
    logic [15:0] map_checksum;
  } sasc_ctrl_word_t;

  // Input status word toward the controller
  typedef struct packed {
    logic [7:0] node_id_value;
    logic map_check_fail;
    logic node_id_conflict;
    logic alarm_ack_flag;
    logic clear_state_flag;
    logic alarm_pending;
  } sasc_status_word_t;

  function automatic logic sasc_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

endpackage

// File: sasc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sasc_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Runs free of the clock enable so no edge is lost while frozen
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule
`default_nettype wire

// File: sasc_alarm.sv
`timescale 1ns/1ps
`default_nettype none
module sasc_alarm
  import sasc_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_enable,
  // Events
  input wire logic i_raise_rise,
  input wire logic i_ack_pulse,
  // Results
  output logic o_notify,
  output logic o_pending,
  output logic o_ack_flag
);

  sasc_alarm_state_t state_ff, nxt_state;
  logic notify_ff, nxt_notify;

  assign nxt_notify = i_enable && i_raise_rise &&
                      (state_ff != SASC_PEND);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SASC_IDLE: begin
        if (nxt_notify) nxt_state = SASC_PEND;
      end
      SASC_PEND: begin
        if (i_ack_pulse) nxt_state = SASC_ACKD;
      end
      SASC_ACKD: begin
        if (nxt_notify) nxt_state = SASC_PEND;
      end
      default: nxt_state = SASC_IDLE;
    endcase
    if (!i_enable) nxt_state = SASC_IDLE;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= SASC_IDLE;
      notify_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      notify_ff <= nxt_notify;
    end
  end

  assign o_notify = notify_ff;
  assign o_pending = (state_ff == SASC_PEND);
  assign o_ack_flag = (state_ff != SASC_ACKD);

  property p_ack_low;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_enable && o_pending && i_ack_pulse |=> !o_ack_flag;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("ack flag not low after acknowledge");

  // Flag may only fall on an acknowledge of a pending alarm
  property p_ack_high;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_ack_flag |-> $past(!o_ack_flag) || $past(o_pending && i_ack_pulse);
  endproperty
  a_ack_high: assert property (p_ack_high)
    else $error("ack flag low without acknowledge");

  property p_one_alarm;
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && o_pending && i_raise_rise && !i_ack_pulse && i_enable
      |=> o_pending && !o_notify;
  endproperty
  a_one_alarm: assert property (p_one_alarm)
    else $error("second alarm accepted while pending");

  c_ack_cycle: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    o_notify ##[1:50] !o_ack_flag);

endmodule
`default_nettype wire

// File: sasc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sasc_top
  import sasc_pkg::*;
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Register port
  input wire logic [sasc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [sasc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [sasc_pkg::DATA_W-1:0] o_rdata,
  // Controller side
  input wire sasc_pkg::sasc_ctrl_word_t i_ctrl_word,
  output sasc_pkg::sasc_status_word_t o_status,
  // Fieldbus master side
  input wire logic i_master_clear,
  input wire logic i_master_alarm_ack,
  output logic o_alarm_notify,
  // Interrupt
  output logic o_irq
);

  // Reset release
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // Master levels arrive from the fieldbus engine's own timing
  logic [1:0] master_sync;
  logic clear_s;
  logic ack_s;
  logic ack_prev_ff;
  logic ack_pulse;

  sasc_sync #(.W(2)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n_ff),
    .i_async({i_master_alarm_ack, i_master_clear}),
    .o_sync(master_sync)
  );

  assign clear_s = master_sync[0];
  assign ack_s = master_sync[1];

  // Register file
  logic ctrl_ff;
  logic [NODE_W-1:0] node_ff;
  logic [SUM_W-1:0] map_sum_ff;
  logic [EVT_W-1:0] irq_stat_ff;
  logic [EVT_W-1:0] irq_mask_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic irq_ff;

  logic wr_ctrl;
  logic wr_node;
  logic wr_sum;
  logic wr_stat;
  logic wr_mask;

  assign wr_ctrl = i_wr && (i_addr == OFS_CTRL);
  assign wr_node = i_wr && (i_addr == OFS_NODE);
  assign wr_sum = i_wr && (i_addr == OFS_MAP_SUM);
  assign wr_stat = i_wr && (i_addr == OFS_IRQ_STAT);
  assign wr_mask = i_wr && (i_addr == OFS_IRQ_MASK);

  logic slave_en;
  assign slave_en = ctrl_ff;

  // Controller side edge of the raise request
  logic raise_prev_ff;
  logic raise_rise;

  assign raise_rise = sasc_rise(i_ctrl_word.alarm_raise_request,
                                raise_prev_ff);
  assign ack_pulse = sasc_rise(ack_s, ack_prev_ff);

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      raise_prev_ff <= 1'b0;
      ack_prev_ff <= 1'b0;
    end else if (i_ce) begin
      raise_prev_ff <= i_ctrl_word.alarm_raise_request;
      ack_prev_ff <= ack_s;
    end
  end

  // Alarm tracker
  logic alarm_pending;
  logic alarm_ack_flag;

  sasc_alarm u_alarm (
    .i_clk(i_clk),
    .i_rst_n(rst_n_ff),
    .i_ce(i_ce),
    .i_enable(slave_en),
    .i_raise_rise(raise_rise),
    .i_ack_pulse(ack_pulse),
    .o_notify(o_alarm_notify),
    .o_pending(alarm_pending),
    .o_ack_flag(alarm_ack_flag)
  );

  // Status word evaluation
  logic nxt_clear_flag;
  logic nxt_map_fail;
  logic nxt_conflict;
  sasc_status_word_t status_ff;
  sasc_status_word_t nxt_status;

  // Out of slave mode the clear state is reported as inactive
  assign nxt_clear_flag = slave_en ? ~clear_s : 1'b1;
  // Compared every cycle, so any change on either side shows
  assign nxt_map_fail = (i_ctrl_word.map_checksum != map_sum_ff);
  assign nxt_conflict = (i_ctrl_word.node_id_value != node_ff);

  always_comb begin
    nxt_status = '0;
    nxt_status.node_id_value = node_ff;
    nxt_status.map_check_fail = nxt_map_fail;
    nxt_status.node_id_conflict = nxt_conflict;
    nxt_status.alarm_ack_flag = alarm_ack_flag;
    nxt_status.clear_state_flag = nxt_clear_flag;
    nxt_status.alarm_pending = alarm_pending;
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      status_ff <= '{node_id_value: NODE_RST, map_check_fail: 1'b0,
                     node_id_conflict: 1'b0, alarm_ack_flag: 1'b1,
                     clear_state_flag: 1'b1, alarm_pending: 1'b0};
    end else if (i_ce) begin
      status_ff <= nxt_status;
    end
  end

  assign o_status = status_ff;

  // Interrupt events: the notify pulse, and edges of the next status word over the registered one
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] nxt_irq_stat;
  logic [EVT_W-1:0] stat_clr;

  assign events[EV_NOTIFY] = o_alarm_notify;
  assign events[EV_ACKED] = sasc_rise(~nxt_status.alarm_ack_flag,
                                      ~status_ff.alarm_ack_flag);
  assign events[EV_CLEAR] = sasc_rise(~nxt_status.clear_state_flag,
                                      ~status_ff.clear_state_flag);
  assign events[EV_MAP_FAIL] = sasc_rise(nxt_status.map_check_fail,
                                         status_ff.map_check_fail);
  assign events[EV_CONFLICT] = sasc_rise(nxt_status.node_id_conflict,
                                         status_ff.node_id_conflict);

  assign stat_clr = wr_stat ? i_wdata[EVT_W-1:0] : '0;
  // A new event outranks a same-cycle write-one-to-clear
  assign nxt_irq_stat = (irq_stat_ff & ~stat_clr) | events;

  // Read decode
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] ctrl_word_rd;

  assign status_word = {status_ff.node_id_value, 3'h0,
                        status_ff.map_check_fail, status_ff.node_id_conflict,
                        status_ff.alarm_ack_flag, status_ff.clear_state_flag,
                        status_ff.alarm_pending};
  assign ctrl_word_rd = {i_ctrl_word.alarm_raise_request, 7'h00,
                         i_ctrl_word.node_id_value};

  always_comb begin
    if (i_addr == OFS_CTRL) begin
      rd_word = {15'h0000, ctrl_ff};
    end else if (i_addr == OFS_NODE) begin
      rd_word = {8'h00, node_ff};
    end else if (i_addr == OFS_MAP_SUM) begin
      rd_word = map_sum_ff;
    end else if (i_addr == OFS_STATUS) begin
      rd_word = status_word;
    end else if (i_addr == OFS_IRQ_STAT) begin
      rd_word = {11'h000, irq_stat_ff};
    end else if (i_addr == OFS_IRQ_MASK) begin
      rd_word = {11'h000, irq_mask_ff};
    end else if (i_addr == OFS_CTRL_WORD) begin
      rd_word = ctrl_word_rd;
    end else begin
      rd_word = 16'h0000;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= CTRL_RST;
      node_ff <= NODE_RST;
      map_sum_ff <= MAP_SUM_RST;
      irq_mask_ff <= MASK_RST;
    end else if (i_ce) begin
      if (wr_ctrl) ctrl_ff <= i_wdata[CTRL_SLAVE_EN_BIT];
      if (wr_node) node_ff <= i_wdata[NODE_W-1:0];
      if (wr_sum) map_sum_ff <= i_wdata;
      if (wr_mask) irq_mask_ff <= i_wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
      rdata_ff <= '0;
    end else if (i_ce) begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
      rdata_ff <= i_rd ? rd_word : 16'h0000;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_irq = irq_ff;

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n_ff);

  property p_clear_flag;
    i_ce && slave_en && clear_s |=> !o_status.clear_state_flag;
  endproperty
  a_clear_flag: assert property (p_clear_flag)
    else $error("clear state not reported as 0");

  property p_clear_idle;
    i_ce && !clear_s |=> o_status.clear_state_flag;
  endproperty
  a_clear_idle: assert property (p_clear_idle)
    else $error("clear state reported without master clear");

  property p_ack_pending;
    o_status.alarm_pending |-> o_status.alarm_ack_flag;
  endproperty
  a_ack_pending: assert property (p_ack_pending)
    else $error("ack flag low while alarm pending");

  property p_map_fail;
    i_ce |=> o_status.map_check_fail ==
      ($past(i_ctrl_word.map_checksum) != $past(map_sum_ff));
  endproperty
  a_map_fail: assert property (p_map_fail)
    else $error("mapping fail flag wrong");

  property p_sum_change;
    i_ce && wr_sum && (i_wdata != i_ctrl_word.map_checksum) &&
      $stable(i_ctrl_word.map_checksum) ##1 i_ce &&
      $stable(i_ctrl_word.map_checksum) |=> o_status.map_check_fail;
  endproperty
  a_sum_change: assert property (p_sum_change)
    else $error("mapping fail not re-evaluated");

  property p_notify_edge;
    o_alarm_notify |-> $past(i_ctrl_word.alarm_raise_request) &&
      !$past(raise_prev_ff);
  endproperty
  a_notify_edge: assert property (p_notify_edge)
    else $error("notify without raise edge");

  property p_level_quiet;
    i_ce && raise_prev_ff && i_ctrl_word.alarm_raise_request
      |=> !o_alarm_notify;
  endproperty
  a_level_quiet: assert property (p_level_quiet)
    else $error("notify on steady raise level");

  property p_node_id;
    i_ce |=> o_status.node_id_value == $past(node_ff);
  endproperty
  a_node_id: assert property (p_node_id)
    else $error("station number not reported");

  property p_conflict;
    i_ce |=> o_status.node_id_conflict ==
      ($past(i_ctrl_word.node_id_value) != $past(node_ff));
  endproperty
  a_conflict: assert property (p_conflict)
    else $error("node conflict flag wrong");

  property p_irq;
    i_ce |=> o_irq == |($past(nxt_irq_stat) & $past(irq_mask_ff));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output wrong");

  property p_rdata_idle;
    i_ce && !i_rd |=> o_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read");

  property p_ce_freeze;
    !i_ce |=> $stable(o_status) && $stable(o_irq) && $stable(o_rdata);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved with clock enable low");

  property p_irq_sticky;
    i_ce && !wr_stat |=>
      (irq_stat_ff & $past(irq_stat_ff)) == $past(irq_stat_ff);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("status bit lost without clear");

  property p_clear_off;
    i_ce && !slave_en |=> o_status.clear_state_flag;
  endproperty
  a_clear_off: assert property (p_clear_off)
    else $error("clear state reported outside slave mode");

  c_notify: cover property (i_ce && raise_rise && slave_en ##1
    o_alarm_notify);
  c_clear: cover property (slave_en && !o_status.clear_state_flag);
  c_map_fail: cover property (o_status.map_check_fail ##1 o_irq);

endmodule
`default_nettype wire

// File: sasc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sasc_master_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Scenario controls
  input wire logic i_clear_req,
  input wire logic i_allow_ack,
  input wire logic [7:0] i_delay,
  // Device pins
  input wire logic i_alarm_notify,
  output logic o_master_clear,
  output logic o_master_alarm_ack
);
  logic seen_ff;
  int cnt_ff;

  // Clear mode is a plain level held by the master
  assign o_master_clear = i_clear_req;

  // Ack level held 4 clocks each way, above the 3-clock minimum
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_ff <= 1'b0;
      cnt_ff <= 0;
      o_master_alarm_ack <= 1'b0;
    end else begin
      if (i_alarm_notify === 1'b1) begin
        seen_ff <= 1'b1;
      end
      if (seen_ff && i_allow_ack) begin
        cnt_ff <= cnt_ff + 1;
        if (cnt_ff == i_delay + 1) begin
          o_master_alarm_ack <= 1'b1;
        end
        if (cnt_ff == i_delay + 5) begin
          o_master_alarm_ack <= 1'b0;
        end
        if (cnt_ff == i_delay + 9) begin
          seen_ff <= 1'b0;
          cnt_ff <= 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: test_slave_alarm_status_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_slave_alarm_status_control;
  import sasc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_ce = 1'b1;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [DATA_W-1:0] o_rdata;
  sasc_ctrl_word_t cw = '0;
  sasc_status_word_t o_status;
  logic mclear;
  logic mack;
  logic o_alarm_notify;
  logic o_irq;
  logic clear_req = 1'b0;
  logic allow_ack = 1'b0;
  logic [7:0] delay = 8'h00;
  int errors = 0;
  int n_checks = 0;
  int n_notify = 0;

  always #12.5 i_clk = ~i_clk;

  sasc_top dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_ctrl_word(cw), .o_status(o_status),
    .i_master_clear(mclear), .i_master_alarm_ack(mack),
    .o_alarm_notify(o_alarm_notify), .o_irq(o_irq)
  );

  sasc_master_model master (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_clear_req(clear_req),
    .i_allow_ack(allow_ack), .i_delay(delay),
    .i_alarm_notify(o_alarm_notify), .o_master_clear(mclear),
    .o_master_alarm_ack(mack)
  );

  // A pulse longer than one cycle would count twice
  always @(posedge i_clk) begin
    if (o_alarm_notify === 1'b1) begin
      n_notify <= n_notify + 1;
    end
  end

  task automatic conclude();
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp,
                    input string what);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(what, exp, o_rdata);
  endtask

  task automatic drive(input logic [7:0] n, input logic r,
                       input logic [15:0] s);
    @(posedge i_clk);
    cw <= {n, r, s};
  endtask

  // Flags are {map fail, conflict, ack, clear, pending}
  task automatic st(input logic [7:0] n, input logic [4:0] f);
    // Status is registered one edge after its inputs settle
    @(posedge i_clk);
    @(negedge i_clk);
    chk("status port", {3'h0, n, f}, {3'h0, o_status});
    rd(OFS_STATUS, {n, 3'h0, f}, "status reg");
  endtask

  task automatic irq(input logic v);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk("irq", {15'h0000, v}, {15'h0000, o_irq});
  endtask

  task automatic wait_ack(input logic v);
    int i;
    for (i = 0; i < 100 && o_status.alarm_ack_flag !== v; i++) begin
      @(negedge i_clk);
    end
    if (i == 100) begin
      errors++;
      $display("Error ack flag expected %h seen timeout", v);
      conclude();
    end
  endtask

  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    st(8'h00, 5'b00110);
    rd(OFS_CTRL, 16'h0000, "ctrl");
    rd(OFS_NODE, 16'h0000, "node");
    rd(OFS_MAP_SUM, 16'h0000, "map sum");
    rd(OFS_IRQ_MASK, 16'h0000, "mask");
    rd(4'hf, 16'h0000, "unmapped");
    drive(8'h02, 1'b0, 16'h347c);
    wr(OFS_NODE, 16'h0002);
    wr(OFS_MAP_SUM, 16'h347c);
    wr(OFS_IRQ_MASK, 16'h001f);
    wr(OFS_CTRL, 16'h0001);
    wr(OFS_IRQ_STAT, 16'h001f);
    irq(1'b0);
    st(8'h02, 5'b00110);
    rd(OFS_CTRL_WORD, 16'h0002, "ctrl word");
    // Write with the clock enable low is dropped
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(OFS_NODE, 16'h0009);
    i_ce <= 1'b1;
    rd(OFS_NODE, 16'h0002, "node frozen");
    // Station conflict raises the interrupt, then W1C clears it
    drive(8'h03, 1'b0, 16'h347c);
    st(8'h02, 5'b01110);
    irq(1'b1);
    rd(OFS_IRQ_STAT, 16'h0010, "irq stat");
    wr(OFS_IRQ_STAT, 16'h0010);
    drive(8'h02, 1'b0, 16'h347c);
    st(8'h02, 5'b00110);
    irq(1'b0);
    // Masked event stays sticky but silent
    wr(OFS_IRQ_MASK, 16'h000f);
    drive(8'h05, 1'b0, 16'h347c);
    st(8'h02, 5'b01110);
    irq(1'b0);
    rd(OFS_IRQ_STAT, 16'h0010, "irq stat");
    wr(OFS_IRQ_MASK, 16'h001f);
    irq(1'b1);
    drive(8'h02, 1'b0, 16'h347c);
    wr(OFS_IRQ_STAT, 16'h0010);
    irq(1'b0);
    // Checksum mismatch from either side
    drive(8'h02, 1'b0, 16'h347d);
    st(8'h02, 5'b10110);
    drive(8'h02, 1'b0, 16'h347c);
    st(8'h02, 5'b00110);
    wr(OFS_MAP_SUM, 16'h1234);
    st(8'h02, 5'b10110);
    wr(OFS_MAP_SUM, 16'h347c);
    st(8'h02, 5'b00110);
    // Clear mode needs sync delay before showing
    @(posedge i_clk);
    clear_req <= 1'b1;
    repeat (5) @(posedge i_clk);
    st(8'h02, 5'b00100);
    @(posedge i_clk);
    clear_req <= 1'b0;
    repeat (5) @(posedge i_clk);
    st(8'h02, 5'b00110);
    wr(OFS_IRQ_STAT, 16'h001f);
    // Alarm with a slow master; steady high and re-raise are ignored
    drive(8'h02, 1'b1, 16'h347c);
    repeat (3) @(posedge i_clk);
    chk("notify count", 16'h0001, n_notify[15:0]);
    st(8'h02, 5'b00111);
    repeat (10) @(posedge i_clk);
    chk("notify count", 16'h0001, n_notify[15:0]);
    drive(8'h02, 1'b0, 16'h347c);
    drive(8'h02, 1'b1, 16'h347c);
    repeat (4) @(posedge i_clk);
    chk("notify count", 16'h0001, n_notify[15:0]);
    @(posedge i_clk);
    allow_ack <= 1'b1;
    delay <= 8'h10;
    wait_ack(1'b0);
    st(8'h02, 5'b00010);
    rd(OFS_IRQ_STAT, 16'h0003, "irq stat");
    wr(OFS_IRQ_STAT, 16'h0003);
    rd(OFS_IRQ_STAT, 16'h0000, "irq stat");
    irq(1'b0);
    // Second alarm with a prompt master
    @(posedge i_clk);
    delay <= 8'h00;
    drive(8'h02, 1'b0, 16'h347c);
    repeat (12) @(posedge i_clk);
    drive(8'h02, 1'b1, 16'h347c);
    repeat (3) @(posedge i_clk);
    chk("notify count", 16'h0002, n_notify[15:0]);
    @(negedge i_clk);
    chk("ack flag", 16'h0001, {15'h0000, o_status.alarm_ack_flag});
    wait_ack(1'b0);
    // Slave mode off refuses a raise
    wr(OFS_CTRL, 16'h0000);
    drive(8'h02, 1'b0, 16'h347c);
    drive(8'h02, 1'b1, 16'h347c);
    repeat (4) @(posedge i_clk);
    chk("notify count", 16'h0002, n_notify[15:0]);
    st(8'h02, 5'b00110);
    conclude();
  end
endmodule
`default_nettype wire
